// *** design/csm_pkg.sv ***
// Constants, types and helpers for the clock select and module stop block.
// Assumes a 24-bit byte address space and 16-bit registers on a plain port.
package csm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          CSM_ADDR_W  = 24;
   localparam int          CSM_DATA_W  = 16;
   localparam logic [23:0] CSM_SCR_OFF = 24'hFFFDC4;
   localparam logic [23:0] CSM_MSA_OFF = 24'hFFFDC8;
   localparam logic [23:0] CSM_MSB_OFF = 24'hFFFDCA;
   localparam logic [23:0] CSM_MSC_OFF = 24'hFFFDCC;
   localparam logic [23:0] CSM_STA_OFF = 24'hFFFDCE;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CSM_SEL_W     = 3;
   localparam int CSM_CORE_LSB  = 8;
   localparam int CSM_PERI_LSB  = 4;
   localparam int CSM_BUS_LSB   = 0;
   localparam int CSM_ALLST_BIT = 15;
   localparam int CSM_STA_ALL   = 0;
   localparam int CSM_STA_ARMED = 1;

   // ----------------------------------------------------------------
   // Writable bits, module bits, core-clocked modules, reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] CSM_SCR_MASK  = 16'h0777;
   localparam logic [15:0] CSM_MSA_WMASK = 16'hB329;
   localparam logic [15:0] CSM_MSA_MASK  = 16'h3329;
   localparam logic [15:0] CSM_MSB_MASK  = 16'h97C0;
   localparam logic [15:0] CSM_MSC_MASK  = 16'hFC1F;
   localparam logic [15:0] CSM_MSA_CORE  = 16'h3000;
   localparam logic [15:0] CSM_MSC_CORE  = 16'h001F;
   localparam logic [15:0] CSM_SCR_RST   = 16'h0111;
   localparam logic [15:0] CSM_MSA_RST   = 16'h3329;
   localparam logic [15:0] CSM_MSB_RST   = 16'h97C0;
   localparam logic [15:0] CSM_MSC_RST   = 16'hFC00;
   localparam logic [2:0]  CSM_SEL_X2    = 3'h1;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CSM_ST_RUN  = 3'h1,
      CSM_ST_SLP  = 3'h2,
      CSM_ST_ALL  = 3'h4
   } csm_state_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } csm_req_t;

   typedef struct packed {
      logic cpu;
      logic periph;
      logic ext_bus;
      logic bus_ctrl;
      logic io;
   } csm_gate_t;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Code 001 runs at the full doubled rate; each step above halves it
   function automatic logic [5:0] csm_div_limit(input logic [2:0] code);
      logic [2:0] sh;
      sh = (code == 3'h0) ? 3'h0 : code - 3'h1;
      return 6'((7'h01 << sh) - 7'h01);
   endfunction

   function automatic logic csm_hit(input logic [23:0] addr, input logic [23:0] off);
      return addr == off;
   endfunction

endpackage

// *** design/csm_clk_div.sv ***
// Rate divider: one-cycle enable tick at a rate picked by a 3-bit code.
// Assumes core_clk is the doubled input clock; code 001 ticks every cycle.
`timescale 1ns/10ps
module csm_clk_div
   import csm_pkg::*;
#(
   parameter int SEL_W = 3,
   parameter int CNT_W = 6
)(
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [SEL_W-1:0] code,
   output logic                  tick
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] limit;
   logic             tick_reg;

   generate
      if (SEL_W != CSM_SEL_W || CNT_W < 6) begin : g_bad
         $error("csm_clk_div: SEL_W must be 3 and CNT_W at least 6");
      end
   endgenerate

   assign limit = CNT_W'(csm_div_limit(code));
   assign tick  = tick_reg;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Compare with >= so a code change to a faster rate never overshoots
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
      end else if (cnt_reg >= limit) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (cnt_reg >= limit);
      end
   end

endmodule

// *** design/csm_clock_stop.sv ***
// Clock select and module stop control: registers, rate ticks, gating.
// Assumes sleep_req and wake_req come from core logic on core_clk.
//
// What this block does
// - Core select bits 10:8; 001 doubles input
// - Peripheral select bits 6:4; 001 doubles input
// - Bus select bits 2:0; 001 doubles input
// - Stop bit 1 stops module, 0 releases
// - Register A bit 15 enables all-stop
// - Sleep with enable and all stopped: all-stop
// - All-stop also halts bus controller, ports
// - Register A module bit assignment
// - Register B module bit assignment
// - Register C module bit assignment
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module csm_clock_stop
   import csm_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire csm_req_t    bus_req,
   output logic [15:0]      rd_data,
   input  wire logic        sleep_req,
   input  wire logic        wake_req,
   output csm_gate_t        gate,
   output logic [15:0]      mod_clk_en_a,
   output logic [15:0]      mod_clk_en_b,
   output logic [15:0]      mod_clk_en_c,
   output logic             all_stop_active
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0] system_clock_control_reg;
   logic [15:0] module_stop_control_a_reg;
   logic [15:0] module_stop_control_b_reg;
   logic [15:0] module_stop_control_c_reg;
   logic [15:0] rd_data_reg;
   logic [15:0] rd_data_next;
   logic [15:0] mod_clk_en_a_reg;
   logic [15:0] mod_clk_en_b_reg;
   logic [15:0] mod_clk_en_c_reg;
   csm_gate_t   gate_reg;
   csm_state_t  state_reg;
   csm_state_t  state_next;
   logic        all_stop_reg;
   logic [2:0]  core_clock_select;
   logic [2:0]  peripheral_clock_select;
   logic [2:0]  bus_clock_select;
   logic        all_clock_stop_enable;
   logic        all_stopped;
   logic        core_tick;
   logic        periph_tick;
   logic        bus_tick;
   logic        wr_scr;
   logic        wr_msa;
   logic        wr_msb;
   logic        wr_msc;
   logic [15:0] grp_a_tick;
   logic [15:0] grp_c_tick;

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   assign core_clock_select       = system_clock_control_reg[CSM_CORE_LSB +: CSM_SEL_W];
   assign peripheral_clock_select = system_clock_control_reg[CSM_PERI_LSB +: CSM_SEL_W];
   assign bus_clock_select        = system_clock_control_reg[CSM_BUS_LSB +: CSM_SEL_W];
   assign all_clock_stop_enable   = module_stop_control_a_reg[CSM_ALLST_BIT];

   // Every controlled module must be stopped; bit 15 of A is not a module
   assign all_stopped = ((module_stop_control_a_reg & CSM_MSA_MASK) == CSM_MSA_MASK)
                     && ((module_stop_control_b_reg & CSM_MSB_MASK) == CSM_MSB_MASK)
                     && ((module_stop_control_c_reg & CSM_MSC_MASK) == CSM_MSC_MASK);

   assign wr_scr = bus_req.wr && csm_hit(bus_req.addr, CSM_SCR_OFF);
   assign wr_msa = bus_req.wr && csm_hit(bus_req.addr, CSM_MSA_OFF);
   assign wr_msb = bus_req.wr && csm_hit(bus_req.addr, CSM_MSB_OFF);
   assign wr_msc = bus_req.wr && csm_hit(bus_req.addr, CSM_MSC_OFF);

   // ----------------------------------------------------------------
   // Rate dividers
   // ----------------------------------------------------------------
   csm_clk_div #(.SEL_W(CSM_SEL_W), .CNT_W(6)) u_core_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .code     (core_clock_select),
      .tick     (core_tick)
   );

   csm_clk_div #(.SEL_W(CSM_SEL_W), .CNT_W(6)) u_peri_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .code     (peripheral_clock_select),
      .tick     (periph_tick)
   );

   csm_clk_div #(.SEL_W(CSM_SEL_W), .CNT_W(6)) u_bus_div (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .code     (bus_clock_select),
      .tick     (bus_tick)
   );

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         system_clock_control_reg <= CSM_SCR_RST;
      end else if (wr_scr) begin
         system_clock_control_reg <= bus_req.wdata & CSM_SCR_MASK;
      end
   end

   // Stop bits are plain storage: set stops, clear releases
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         module_stop_control_a_reg <= CSM_MSA_RST;
      end else if (wr_msa) begin
         module_stop_control_a_reg <= bus_req.wdata & CSM_MSA_WMASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         module_stop_control_b_reg <= CSM_MSB_RST;
      end else if (wr_msb) begin
         module_stop_control_b_reg <= bus_req.wdata & CSM_MSB_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         module_stop_control_c_reg <= CSM_MSC_RST;
      end else if (wr_msc) begin
         module_stop_control_c_reg <= bus_req.wdata & CSM_MSC_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_comb begin
      rd_data_next = 16'h0000;
      if (bus_req.rd) begin
         if (csm_hit(bus_req.addr, CSM_SCR_OFF)) begin
            rd_data_next = system_clock_control_reg;
         end else if (csm_hit(bus_req.addr, CSM_MSA_OFF)) begin
            rd_data_next = module_stop_control_a_reg;
         end else if (csm_hit(bus_req.addr, CSM_MSB_OFF)) begin
            rd_data_next = module_stop_control_b_reg;
         end else if (csm_hit(bus_req.addr, CSM_MSC_OFF)) begin
            rd_data_next = module_stop_control_c_reg;
         end else if (csm_hit(bus_req.addr, CSM_STA_OFF)) begin
            rd_data_next[CSM_STA_ALL]   = all_stopped;
            rd_data_next[CSM_STA_ARMED] = all_stopped && all_clock_stop_enable;
         end
      end
   end

   // Data stand only in the cycle after the strobe; zero otherwise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_reg <= 16'h0000;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         CSM_ST_RUN: begin
            if (sleep_req && all_clock_stop_enable && all_stopped) begin
               state_next = CSM_ST_ALL;
            end else if (sleep_req) begin
               state_next = CSM_ST_SLP;
            end
         end
         CSM_ST_SLP: begin
            if (wake_req) begin
               state_next = CSM_ST_RUN;
            end
         end
         CSM_ST_ALL: begin
            if (wake_req) begin
               state_next = CSM_ST_RUN;
            end
         end
         default: begin
            state_next = CSM_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= CSM_ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         all_stop_reg <= 1'b0;
      end else begin
         all_stop_reg <= (state_next == CSM_ST_ALL);
      end
   end

   // ----------------------------------------------------------------
   // Clock gating
   // ----------------------------------------------------------------
   // Enables, not gated clocks: keeps the block on one clock, no glitches
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_reg <= '0;
      end else begin
         gate_reg.cpu      <= (state_reg == CSM_ST_RUN) && core_tick;
         gate_reg.periph   <= (state_reg != CSM_ST_ALL) && periph_tick;
         gate_reg.ext_bus  <= (state_reg != CSM_ST_ALL) && bus_tick;
         gate_reg.bus_ctrl <= (state_reg != CSM_ST_ALL) && core_tick;
         gate_reg.io       <= (state_reg != CSM_ST_ALL) && periph_tick;
      end
   end

   // DMA, transfer controller and RAM banks follow the core rate
   assign grp_a_tick = (CSM_MSA_CORE & {16{core_tick}}) | (~CSM_MSA_CORE & {16{periph_tick}});
   assign grp_c_tick = (CSM_MSC_CORE & {16{core_tick}}) | (~CSM_MSC_CORE & {16{periph_tick}});

   // A stopped module keeps its state; only its clock enable drops
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mod_clk_en_a_reg <= 16'h0000;
         mod_clk_en_b_reg <= 16'h0000;
         mod_clk_en_c_reg <= 16'h0000;
      end else begin
         mod_clk_en_a_reg <= ~module_stop_control_a_reg & CSM_MSA_MASK & grp_a_tick;
         mod_clk_en_b_reg <= ~module_stop_control_b_reg & CSM_MSB_MASK & {16{periph_tick}};
         mod_clk_en_c_reg <= ~module_stop_control_c_reg & CSM_MSC_MASK & grp_c_tick;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data         = rd_data_reg;
   assign gate            = gate_reg;
   assign mod_clk_en_a    = mod_clk_en_a_reg;
   assign mod_clk_en_b    = mod_clk_en_b_reg;
   assign mod_clk_en_c    = mod_clk_en_c_reg;
   assign all_stop_active = all_stop_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   chk_core_full_rate: assert property (
      (state_reg == CSM_ST_RUN && core_clock_select == CSM_SEL_X2)[*3] |=> gate_reg.cpu
   ) else $error("cpu enable missing at code 001");

   chk_periph_full_rate: assert property (
      (state_reg != CSM_ST_ALL && peripheral_clock_select == CSM_SEL_X2)[*3] |=> gate_reg.periph
   ) else $error("peripheral enable missing at code 001");

   chk_bus_full_rate: assert property (
      (state_reg != CSM_ST_ALL && bus_clock_select == CSM_SEL_X2)[*3] |=> gate_reg.ext_bus
   ) else $error("external bus enable missing at code 001");

   chk_stop_write_gates: assert property (
      wr_msa && bus_req.wdata[0] |-> ##2 !mod_clk_en_a_reg[0]
   ) else $error("pulse timer still clocked after stop write");

   chk_disabled_plain_sleep: assert property (
      state_reg == CSM_ST_RUN && sleep_req && !all_clock_stop_enable |=> state_reg == CSM_ST_SLP
   ) else $error("all-stop entered while disabled");

   chk_all_stop_entry: assert property (
      state_reg == CSM_ST_RUN && sleep_req && all_clock_stop_enable && all_stopped
      |=> state_reg == CSM_ST_ALL && all_stop_reg
   ) else $error("all-stop not entered");

   chk_all_stop_quiet: assert property (
      state_reg == CSM_ST_ALL |=> !gate_reg.bus_ctrl && !gate_reg.io && !gate_reg.cpu
   ) else $error("bus controller or ports clocked in all-stop");

   chk_dma_bit_map: assert property (
      mod_clk_en_a_reg[13] |-> !$past(module_stop_control_a_reg[13]) && $past(core_tick)
   ) else $error("dma engine enable not tied to bit 13");

   chk_serial_bit_map: assert property (
      mod_clk_en_b_reg[8] |-> !$past(module_stop_control_b_reg[8]) && $past(periph_tick)
   ) else $error("serial interface 0 enable not tied to bit 8");

   chk_reg_c_reserved: assert property (
      wr_msc |=> (module_stop_control_c_reg & ~CSM_MSC_MASK) == 16'h0000
   ) else $error("reserved bits of register C stored");

   chk_stopped_no_clock: assert property (
      ((mod_clk_en_a_reg & $past(module_stop_control_a_reg)) == 16'h0000)
      && ((mod_clk_en_c_reg & $past(module_stop_control_c_reg)) == 16'h0000)
   ) else $error("stopped module received a clock enable");

   chk_release_write_clocks: assert property (
      wr_msb && !bus_req.wdata[8] |-> ##2 mod_clk_en_b_reg[8] == $past(periph_tick)
   ) else $error("serial interface 0 not clocked after release write");

   chk_sleep_holds_state: assert property (
      state_reg != CSM_ST_RUN && !wake_req |=> $stable(state_reg)
   ) else $error("sleep state left without wake");

   chk_wake_to_run: assert property (
      state_reg != CSM_ST_RUN && wake_req |=> state_reg == CSM_ST_RUN && !all_stop_reg
   ) else $error("wake did not return to run");

   chk_all_stop_periph: assert property (
      state_reg == CSM_ST_ALL |=> !gate_reg.periph && !gate_reg.ext_bus
   ) else $error("peripheral or external bus clocked in all-stop");

   chk_sleep_keeps_bus: assert property (
      state_reg == CSM_ST_SLP |=> gate_reg.bus_ctrl == $past(core_tick) && gate_reg.io == $past(periph_tick)
   ) else $error("bus controller or ports stopped in plain sleep");

   chk_ram_core_rate: assert property (
      mod_clk_en_c_reg[0] |-> !$past(module_stop_control_c_reg[0]) && $past(core_tick)
   ) else $error("ram bank 0 enable not tied to bit 0");

   chk_b_stopped_quiet: assert property (
      (mod_clk_en_b_reg & $past(module_stop_control_b_reg)) == 16'h0000
   ) else $error("stopped register B module received a clock enable");

   cov_all_stop: cover property (state_reg == CSM_ST_RUN ##1 state_reg == CSM_ST_ALL);
   cov_sleep:    cover property (state_reg == CSM_ST_RUN ##1 state_reg == CSM_ST_SLP);
   cov_wake:     cover property (state_reg == CSM_ST_ALL ##1 state_reg == CSM_ST_RUN);
   cov_slow:     cover property (core_clock_select == 3'h4 && gate_reg.cpu);
   cov_plain_wake: cover property (state_reg == CSM_ST_SLP ##1 state_reg == CSM_ST_RUN);

endmodule

// *** bench/csm_clock_stop_tb.sv ***
// Self-checking bench for the clock select and module stop block.
// Assumes the design package csm_pkg and one 25 MHz clock; bench drives every port.
`timescale 1ns/10ps
module csm_clock_stop_tb;
   import csm_pkg::*;

   // ----------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------
   localparam int LIMIT = 12000;
   logic        core_clk;
   logic        rst_b;
   csm_req_t    bus_req;
   logic [15:0] rd_data;
   logic        sleep_req;
   logic        wake_req;
   csm_gate_t   gate;
   logic [15:0] mod_clk_en_a;
   logic [15:0] mod_clk_en_b;
   logic [15:0] mod_clk_en_c;
   logic        all_stop_active;
   logic [15:0] m_scr, m_a, m_b, m_c;
   logic [7:0]  cnt [5];
   logic [23:0] tbl [6];
   logic [15:0] d;
   int          errors, n_compared, cyc, seed, k, c;

   csm_clock_stop csm_clock_stop_i (
      .core_clk        (core_clk),
      .rst_b           (rst_b),
      .bus_req         (bus_req),
      .rd_data         (rd_data),
      .sleep_req       (sleep_req),
      .wake_req        (wake_req),
      .gate            (gate),
      .mod_clk_en_a    (mod_clk_en_a),
      .mod_clk_en_b    (mod_clk_en_b),
      .mod_clk_en_c    (mod_clk_en_c),
      .all_stop_active (all_stop_active)
   );

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // Compare, expectation and verdict helpers
   // ----------------------------------------------------------------
   task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmp1(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %0d seen %0d", name, exp, got);
      end
   endtask

   function automatic logic all_off();
      return (m_a & CSM_MSA_MASK) == CSM_MSA_MASK && m_b == CSM_MSB_MASK && m_c == CSM_MSC_MASK;
   endfunction

   function automatic logic [15:0] exp_rd(input logic [23:0] a);
      case (a)
         CSM_SCR_OFF: return m_scr;
         CSM_MSA_OFF: return m_a;
         CSM_MSB_OFF: return m_b;
         CSM_MSC_OFF: return m_c;
         CSM_STA_OFF: return {14'h0000, all_off() & m_a[CSM_ALLST_BIT], all_off()};
         default:     return 16'h0000;
      endcase
   endfunction

   // Ticks expected in a 128-cycle window; code 000 runs like 001
   function automatic logic [7:0] exp_cnt(input logic [2:0] code);
      return (code == 3'h0) ? 8'h80 : 8'(8'h80 >> (code - 3'h1));
   endfunction

   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         errors++;
         results();
      end
   end

   // ----------------------------------------------------------------
   // Bus, reset and power tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [23:0] a, input logic [15:0] v);
      @(posedge core_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= v;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      case (a)
         CSM_SCR_OFF: m_scr = v & CSM_SCR_MASK;
         CSM_MSA_OFF: m_a = v & CSM_MSA_WMASK;
         CSM_MSB_OFF: m_b = v & CSM_MSB_MASK;
         CSM_MSC_OFF: m_c = v & CSM_MSC_MASK;
         default: ;
      endcase
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string name, input logic [23:0] a);
      @(posedge core_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 cmp16(name, exp_rd(a), rd_data);
      @(posedge core_clk);
      #1 cmp16("rd_data idle", 16'h0000, rd_data);
   endtask

   task automatic do_reset();
      @(posedge core_clk);
      rst_b <= 1'b0;
      @(posedge core_clk);
      #1 cmp16("outputs in reset", 16'h0000, {gate, all_stop_active, mod_clk_en_a[9:0]});
      @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      m_scr = CSM_SCR_RST;
      m_a = CSM_MSA_RST;
      m_b = CSM_MSB_RST;
      m_c = CSM_MSC_RST;
      rd_chk("clock control", CSM_SCR_OFF);
      rd_chk("stop A", CSM_MSA_OFF);
      rd_chk("stop B", CSM_MSB_OFF);
      rd_chk("stop C", CSM_MSC_OFF);
   endtask

   task automatic enables_chk();
      repeat (3) @(posedge core_clk);
      #1 cmp16("mod_clk_en_a", ~m_a & CSM_MSA_MASK, mod_clk_en_a);
      cmp16("mod_clk_en_b", ~m_b & CSM_MSB_MASK, mod_clk_en_b);
      cmp16("mod_clk_en_c", ~m_c & CSM_MSC_MASK, mod_clk_en_c);
   endtask

   task automatic pulse_sleep(input logic all);
      rd_chk("status", CSM_STA_OFF);
      @(posedge core_clk);
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      #1 cmp1("all_stop_active", all, all_stop_active);
      repeat (2) @(posedge core_clk);
      repeat (8) begin
         #1 cmp1("gate.cpu asleep", 1'b0, gate.cpu);
         cmp1("gate.bus_ctrl", ~all, gate.bus_ctrl);
         cmp1("gate.io", ~all, gate.io);
         cmp1("gate.periph", ~all, gate.periph);
         cmp1("gate.ext_bus", ~all, gate.ext_bus);
         cmp16("mod_clk_en_c asleep", all ? 16'h0000 : ~m_c & CSM_MSC_MASK, mod_clk_en_c);
         @(posedge core_clk);
      end
      wake_req <= 1'b1;
      @(posedge core_clk);
      wake_req <= 1'b0;
      #1 cmp1("all_stop_active woken", 1'b0, all_stop_active);
      repeat (3) @(posedge core_clk);
      #1 cmp1("gate.cpu woken", 1'b1, gate.cpu);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      bus_req = '0;
      sleep_req = 1'b0;
      wake_req = 1'b0;
      errors = 0;
      n_compared = 0;
      cyc = 0;
      seed = 32'h0C898014;
      tbl = '{CSM_MSA_OFF, CSM_MSB_OFF, CSM_MSC_OFF, CSM_STA_OFF, 24'hFFFDC6, 24'hFFFDC5};
      do_reset();
      enables_chk();

      // Every code on every field, reserved bits set to be dropped
      for (c = 0; c < 8; c++) begin
         d = 16'hF888 | (16'(c) << 8) | (16'((c + 3) % 8) << 4) | 16'((c + 5) % 8);
         wr(CSM_SCR_OFF, d);
         rd_chk("clock control", CSM_SCR_OFF);
         repeat (70) @(posedge core_clk);
         cnt = '{default: 8'h00};
         repeat (128) begin
            @(posedge core_clk);
            #1 cnt[0] += gate.cpu;
            cnt[1] += gate.bus_ctrl;
            cnt[2] += gate.periph;
            cnt[3] += gate.io;
            cnt[4] += gate.ext_bus;
            cmp16("stopped a", 16'h0000, mod_clk_en_a & (m_a | ~CSM_MSA_MASK));
         end
         cmp8("cpu ticks", exp_cnt(m_scr[10:8]), cnt[0]);
         cmp8("bus_ctrl ticks", exp_cnt(m_scr[10:8]), cnt[1]);
         cmp8("periph ticks", exp_cnt(m_scr[6:4]), cnt[2]);
         cmp8("io ticks", exp_cnt(m_scr[6:4]), cnt[3]);
         cmp8("ext_bus ticks", exp_cnt(m_scr[2:0]), cnt[4]);
      end
      wr(CSM_SCR_OFF, 16'h0111);

      // Random stop patterns, read-only and unmapped places among them
      for (k = 0; k < 24; k++) begin
         c = $unsigned($random(seed)) % 6;
         wr(tbl[c], 16'($random(seed)));
         rd_chk("random read", tbl[c]);
         enables_chk();
      end
      wr(CSM_MSA_OFF, 16'hFFFF);
      wr(CSM_MSB_OFF, 16'h0000);
      enables_chk();
      wr(CSM_MSB_OFF, 16'hFFFF);
      wr(CSM_MSC_OFF, 16'h0000);
      enables_chk();

      // Sleep: enable off, one bank running, then everything stopped
      wr(CSM_MSA_OFF, 16'h3329);
      wr(CSM_MSC_OFF, 16'hFC1F);
      pulse_sleep(1'b0);
      wr(CSM_MSA_OFF, 16'hB329);
      wr(CSM_MSC_OFF, 16'hFC0F);
      pulse_sleep(1'b0);
      wr(CSM_MSC_OFF, 16'hFC1F);
      pulse_sleep(1'b1);

      do_reset();
      results();
   end
endmodule
